/* hw/qcmd_pkg.sv */
// shared constants and carriers for the four-lane command decoder
package qcmd_pkg;
  // opcodes
  localparam logic [7:0] OP_ERASE_EVAL    = 8'hD0;
  localparam logic [7:0] OP_WEAR_COUNT    = 8'h5D;
  localparam logic [7:0] OP_SUSPEND       = 8'h75;
  localparam logic [7:0] OP_SUSPEND_ALT_A = 8'h85;
  localparam logic [7:0] OP_SUSPEND_ALT_B = 8'hB0;
  localparam logic [7:0] OP_RESUME        = 8'h7A;
  localparam logic [7:0] OP_RESUME_ALT_A  = 8'h8A;
  localparam logic [7:0] OP_RESUME_ALT_B  = 8'h30;
  localparam logic [7:0] OP_OTP_PROGRAM   = 8'h42;
  localparam logic [7:0] OP_OTP_READ      = 8'h4B;
  localparam logic [7:0] OP_PROT_READ_CUR = 8'hFA;
  localparam logic [7:0] OP_PROT_READ_4B  = 8'hE0;
  // byte and nibble counts and fifo depth
  localparam int ADDR_BYTES_SHORT = 3;
  localparam int ADDR_BYTES_LONG  = 4;
  localparam int NIBBLES_PER_BYTE = 2;
  localparam int FIFO_DEPTH       = 8;

  typedef enum logic [3:0] {
    CMD_NONE       = 4'h0,
    CMD_ERASE_EVAL = 4'h1,
    CMD_WEAR_COUNT = 4'h2,
    CMD_SUSPEND    = 4'h3,
    CMD_RESUME     = 4'h4,
    CMD_OTP_PROG   = 4'h5,
    CMD_OTP_READ   = 4'h6,
    CMD_PROT_READ  = 4'h7
  } cmd_kind_t;

  // one decoded request handed from the link domain to the core domain
  typedef struct packed {
    cmd_kind_t   kind;
    logic [31:0] addr;
    logic [7:0]  data;
    logic        last;
  } core_req_t;

  // four-lane pin drive, split into output and enable
  typedef struct packed {
    logic [3:0] dq_out;
    logic [3:0] dq_oe;
  } lane_drive_t;
endpackage

/* hw/req_fifo.sv */
// two-clock fifo with gray-coded pointers carrying decoded requests
`timescale 1ns/100ps
module req_fifo #(
  parameter int WIDTH = 45,
  parameter int DEPTH = 8
) (
  input  wire logic             wr_clock,
  input  wire logic             wr_rst,
  input  wire logic             wr_valid,
  output      logic             wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_clock,
  input  wire logic             rd_rst,
  output      logic             rd_valid,
  input  wire logic             rd_ready,
  output      logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wbin_r, rbin_r, wgray_r, rgray_r;
  logic [AW:0] rg_s1_r, rg_s2_r, wg_s1_r, wg_s2_r;
  logic [AW:0] wbin_nxt, rbin_nxt;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  assign wr_ready = (wgray_r != {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]});
  assign rd_valid = (rgray_r != wg_s2_r);
  assign wbin_nxt = wbin_r + (AW+1)'(wr_valid && wr_ready);
  assign rbin_nxt = rbin_r + (AW+1)'(rd_valid && rd_ready);
  assign rd_data  = mem[rbin_r[AW-1:0]];

  always_ff @(posedge wr_clock) begin
    if (wr_valid && wr_ready) begin
      mem[wbin_r[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge wr_clock) begin
    if (wr_rst) begin
      wbin_r  <= '0;
      wgray_r <= '0;
      rg_s1_r <= '0;
      rg_s2_r <= '0;
    end else begin
      wbin_r  <= wbin_nxt;
      wgray_r <= to_gray(wbin_nxt);
      rg_s1_r <= rgray_r;
      rg_s2_r <= rg_s1_r;
    end
  end

  always_ff @(posedge rd_clock) begin
    if (rd_rst) begin
      rbin_r  <= '0;
      rgray_r <= '0;
      wg_s1_r <= '0;
      wg_s2_r <= '0;
    end else begin
      rbin_r  <= rbin_nxt;
      rgray_r <= to_gray(rbin_nxt);
      wg_s1_r <= wgray_r;
      wg_s2_r <= wg_s1_r;
    end
  end
endmodule

/* hw/quad_io_cmd_decode.sv */
// four-lane command decoder: link-side shifter, request fifo and core-side executor
`timescale 1ns/100ps
// Notes on behaviour
// - opcode, address and data all move four lanes wide, one byte per two edges.
// - erase-status opcode with sector address pulses erase_eval_req with that address; no reply is driven on the lanes.
// - opcode 5D with address returns that sector's erase-cycle count.
// - opcodes 85 and B0 also suspend a running program or erase.
// - opcodes 8A and 30 also resume the suspended operation.
// - host sends write enable, then 42, address and data bytes to program.
// - opcode 4B with address reads secure region from that address.
// - FA uses current address length, E0 always four bytes; returns protection byte.
module quad_io_cmd_decode
  import qcmd_pkg::*;
#(
  parameter int FIFO_WIDTH = 45
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              link_clock,
  input  wire logic              cs_n,
  input  wire logic [3:0]        dq_in,
  output      qcmd_pkg::lane_drive_t dq_drive,
  input  wire logic              addr_4byte_mode,
  input  wire logic              wel_set,
  output      logic              wel_clear,
  input  wire logic              core_busy,
  input  wire logic              core_busy_prog_erase,
  output      logic              suspend_req,
  output      logic              resume_req,
  output      logic              suspended,
  output      logic              erase_eval_req,
  output      logic              otp_prog_req,
  output      logic [31:0]       otp_prog_addr,
  output      logic [7:0]        otp_prog_data,
  input  wire logic              otp_prog_done,
  output      logic [31:0]       lookup_addr,
  input  wire logic [7:0]        wear_count_byte,
  input  wire logic [7:0]        otp_read_byte,
  input  wire logic [7:0]        prot_byte
);
  import qcmd_pkg::*;

  // ----------------------------------------------------------------
  // link domain: chip select synchroniser and nibble shifter
  // ----------------------------------------------------------------
  // cs_n comes from the pin; three stages, a change counts when 2 and 3 agree
  logic [2:0] cs_sync_r;
  logic       link_rst;
  logic       link_sel_r;
  logic       rst_s1_r, rst_s2_r;

  always_ff @(posedge link_clock) begin
    cs_sync_r <= {cs_sync_r[1:0], cs_n};
    rst_s1_r  <= sys_rst;
    rst_s2_r  <= rst_s1_r;
  end
  assign link_rst = rst_s2_r;

  always_ff @(posedge link_clock) begin
    if (link_rst) begin
      link_sel_r <= 1'b0;
    end else if (cs_sync_r[2] == cs_sync_r[1]) begin
      link_sel_r <= ~cs_sync_r[2];
    end
  end

  typedef enum logic [1:0] {
    LS_OPCODE = 2'b00,
    LS_ADDR   = 2'b01,
    LS_DATA   = 2'b11,
    LS_IGNORE = 2'b10
  } link_state_t;

  link_state_t state_r;
  logic        nib_phase_r;
  logic [3:0]  hi_nib_r;
  logic [2:0]  addr_cnt_r;
  logic [2:0]  addr_len_r;
  cmd_kind_t   kind_r;
  logic [31:0] addr_r;
  logic        byte_done;
  logic [7:0]  byte_in;
  core_req_t   push_data;
  logic        push_valid, push_ready;

  function automatic cmd_kind_t decode_op(input logic [7:0] op);
    case (op)
      OP_ERASE_EVAL:                                 decode_op = CMD_ERASE_EVAL;
      OP_WEAR_COUNT:                                 decode_op = CMD_WEAR_COUNT;
      OP_SUSPEND, OP_SUSPEND_ALT_A, OP_SUSPEND_ALT_B: decode_op = CMD_SUSPEND;
      OP_RESUME, OP_RESUME_ALT_A, OP_RESUME_ALT_B:   decode_op = CMD_RESUME;
      OP_OTP_PROGRAM:                                decode_op = CMD_OTP_PROG;
      OP_OTP_READ:                                   decode_op = CMD_OTP_READ;
      OP_PROT_READ_CUR, OP_PROT_READ_4B:             decode_op = CMD_PROT_READ;
      default:                                       decode_op = CMD_NONE;
    endcase
  endfunction

  // lanes ride four stages so each nibble lines up with the synchronised select;
  // without this the edges that carry select through its flops count as data
  logic [15:0] dq_pipe_r;
  logic [3:0]  lane_nib;
  always_ff @(posedge link_clock) begin
    dq_pipe_r <= {dq_pipe_r[11:0], dq_in};
  end
  assign lane_nib = dq_pipe_r[15:12];

  assign byte_in   = {hi_nib_r, lane_nib};
  assign byte_done = link_sel_r && nib_phase_r;

  always_ff @(posedge link_clock) begin
    if (link_rst || !link_sel_r) begin
      nib_phase_r <= 1'b0;
      hi_nib_r    <= 4'h0;
    end else begin
      nib_phase_r <= ~nib_phase_r;
      hi_nib_r    <= lane_nib;
    end
  end

  // address-length selection; the mode level is quasi-static
  logic [1:0] a4_sync_r;
  always_ff @(posedge link_clock) begin
    a4_sync_r <= {a4_sync_r[0], addr_4byte_mode};
  end

  always_ff @(posedge link_clock) begin
    if (link_rst || !link_sel_r) begin
      state_r    <= LS_OPCODE;
      kind_r     <= CMD_NONE;
      addr_cnt_r <= 3'h0;
      addr_len_r <= 3'(ADDR_BYTES_SHORT);
      addr_r     <= 32'h0;
    end else if (byte_done) begin
      case (state_r)
        LS_OPCODE: begin
          kind_r     <= decode_op(byte_in);
          addr_cnt_r <= 3'h0;
          addr_r     <= 32'h0;
          if (byte_in == OP_PROT_READ_4B || a4_sync_r[1]) begin
            addr_len_r <= 3'(ADDR_BYTES_LONG);
          end else begin
            addr_len_r <= 3'(ADDR_BYTES_SHORT);
          end
          case (decode_op(byte_in))
            CMD_NONE:                state_r <= LS_IGNORE;
            CMD_SUSPEND, CMD_RESUME: state_r <= LS_IGNORE;
            default:                 state_r <= LS_ADDR;
          endcase
        end
        LS_ADDR: begin
          addr_r     <= {addr_r[23:0], byte_in};
          addr_cnt_r <= addr_cnt_r + 3'h1;
          if (addr_cnt_r + 3'h1 == addr_len_r) begin
            state_r <= (kind_r == CMD_OTP_PROG) ? LS_DATA : LS_IGNORE;
          end
        end
        LS_DATA: begin
          addr_r <= addr_r + 32'h1;
        end
        default: state_r <= LS_IGNORE;
      endcase
    end
  end

  // requests: single-byte commands at the opcode, reads once the address is in,
  // each program byte as it arrives
  always_comb begin
    push_valid     = 1'b0;
    push_data      = '0;
    push_data.kind = kind_r;
    push_data.addr = {addr_r[23:0], byte_in};
    if (addr_len_r == 3'(ADDR_BYTES_SHORT)) begin
      push_data.addr = {8'h00, addr_r[15:0], byte_in};
    end
    push_data.data = byte_in;
    if (byte_done) begin
      case (state_r)
        LS_OPCODE: begin
          push_data.kind = decode_op(byte_in);
          push_valid     = (decode_op(byte_in) == CMD_SUSPEND) ||
                           (decode_op(byte_in) == CMD_RESUME);
        end
        LS_ADDR: push_valid = (addr_cnt_r + 3'h1 == addr_len_r) && (kind_r != CMD_OTP_PROG);
        LS_DATA: begin
          push_valid     = 1'b1;
          push_data.addr = addr_r;
          // a byte completing as select drops ends the program; a cut byte never marks it
          push_data.last = cs_sync_r[2] && cs_sync_r[1];
        end
        default: push_valid = 1'b0;
      endcase
    end
  end

  logic             pop_valid, pop_ready;
  logic [44:0]      pop_raw;

  // a full fifo drops the byte; eight entries outrun core service at these rates
  req_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .wr_clock (link_clock),
    .wr_rst   (link_rst),
    .wr_valid (push_valid && push_ready),
    .wr_ready (push_ready),
    .wr_data  (push_data),
    .rd_clock (clock),
    .rd_rst   (sys_rst),
    .rd_valid (pop_valid),
    .rd_ready (pop_ready),
    .rd_data  (pop_raw)
  );

  // ----------------------------------------------------------------
  // core domain: executor
  // ----------------------------------------------------------------
  core_req_t        pop_req;
  logic             prog_busy_r, suspended_r;
  logic             prog_last_r;
  logic [7:0]       reply_r;

  assign pop_req   = core_req_t'(pop_raw);
  assign pop_ready = !prog_busy_r;
  assign suspended = suspended_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      suspend_req    <= 1'b0;
      resume_req     <= 1'b0;
      suspended_r    <= 1'b0;
      erase_eval_req <= 1'b0;
      otp_prog_req   <= 1'b0;
      otp_prog_addr  <= 32'h0;
      otp_prog_data  <= 8'h00;
      lookup_addr    <= 32'h0;
      prog_busy_r    <= 1'b0;
      prog_last_r    <= 1'b0;
      wel_clear      <= 1'b0;
    end else begin
      suspend_req    <= 1'b0;
      resume_req     <= 1'b0;
      erase_eval_req <= 1'b0;
      otp_prog_req   <= 1'b0;
      wel_clear      <= 1'b0;
      if (prog_busy_r && otp_prog_done) begin
        prog_busy_r <= 1'b0;
        wel_clear   <= prog_last_r;
      end
      if (pop_valid && pop_ready) begin
        case (pop_req.kind)
          CMD_SUSPEND: begin
            // suspend only when work runs; alternates only while a program or erase runs
            if (!suspended_r &&
                ((pop_req.data == OP_SUSPEND) ? core_busy : core_busy_prog_erase)) begin
              suspend_req <= 1'b1;
              suspended_r <= 1'b1;
            end
          end
          CMD_RESUME: begin
            if (suspended_r) begin
              resume_req  <= 1'b1;
              suspended_r <= 1'b0;
            end
          end
          CMD_ERASE_EVAL: begin
            erase_eval_req <= 1'b1;
            lookup_addr    <= pop_req.addr;
          end
          CMD_WEAR_COUNT, CMD_OTP_READ, CMD_PROT_READ: begin
            lookup_addr <= pop_req.addr;
          end
          CMD_OTP_PROG: begin
            // program byte only with latch set
            if (wel_set) begin
              otp_prog_req  <= 1'b1;
              otp_prog_addr <= pop_req.addr;
              otp_prog_data <= pop_req.data;
              prog_busy_r   <= 1'b1;
              prog_last_r   <= pop_req.last;
            end
          end
          default: lookup_addr <= lookup_addr;
        endcase
      end
    end
  end

  // reply byte chosen by command kind
  cmd_kind_t last_kind_r;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      last_kind_r <= CMD_NONE;
      reply_r     <= 8'h00;
    end else begin
      if (pop_valid && pop_ready) begin
        last_kind_r <= pop_req.kind;
      end
      case (last_kind_r)
        CMD_WEAR_COUNT: reply_r <= wear_count_byte;
        CMD_OTP_READ:   reply_r <= otp_read_byte;
        CMD_PROT_READ:  reply_r <= prot_byte;
        default:        reply_r <= reply_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // link domain: reply driver (word is held steady, sampled through two flops)
  // ----------------------------------------------------------------
  logic [7:0] reply_s1_r, reply_s2_r;
  always_ff @(posedge link_clock) begin
    reply_s1_r <= reply_r;
    reply_s2_r <= reply_s1_r;
  end

  // reply shifted out high nibble first
  always_ff @(posedge link_clock) begin
    if (link_rst || !link_sel_r) begin
      dq_drive <= '0;
    end else if (state_r == LS_IGNORE &&
                 (kind_r == CMD_WEAR_COUNT || kind_r == CMD_OTP_READ ||
                  kind_r == CMD_PROT_READ)) begin
      dq_drive.dq_oe  <= 4'hF;
      dq_drive.dq_out <= nib_phase_r ? reply_s2_r[3:0] : reply_s2_r[7:4];
    end else begin
      dq_drive <= '0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  suspend_guard_a: assert property (@(posedge clock) disable iff (sys_rst)
    suspend_req |-> $past(core_busy) && !$past(suspended_r))
    else $error("suspend issued with nothing running");
  resume_guard_a: assert property (@(posedge clock) disable iff (sys_rst)
    resume_req |-> $past(suspended_r) && !suspended_r)
    else $error("resume issued while not suspended");
  suspend_state_a: assert property (@(posedge clock) disable iff (sys_rst)
    suspend_req |-> suspended_r)
    else $error("suspend did not mark suspended");
  prog_wel_a: assert property (@(posedge clock) disable iff (sys_rst)
    otp_prog_req |-> $past(wel_set))
    else $error("program started without write enable");
  wel_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(wel_clear) |-> !prog_busy_r)
    else $error("latch cleared while program busy");
  prog_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    otp_prog_req |=> prog_busy_r || wel_clear)
    else $error("program not tracked as busy");
  eval_addr_a: assert property (@(posedge clock) disable iff (sys_rst)
    erase_eval_req |-> lookup_addr == $past(pop_req.addr))
    else $error("evaluation address mismatch");
  lane_idle_a: assert property (@(posedge link_clock) disable iff (link_rst)
    !link_sel_r |=> dq_drive.dq_oe == 4'h0)
    else $error("lanes driven while deselected");
endmodule

/* dv/host_qspi_model.sv */
// host-side four-lane controller model: link clock, select and lane drive
`timescale 1ns/100ps
module host_qspi_model
  import qcmd_pkg::*;
(
  output logic                  link_clock,
  output logic                  cs_n,
  output logic [3:0]            dq_in,
  input  wire qcmd_pkg::lane_drive_t dq_drive
);
  logic [3:0] host_val;
  logic       host_oe;
  logic [3:0] last_val;
  int         oe_seen;

  initial begin
    link_clock = 1'b0;
    cs_n = 1'b1;
    host_val = 4'h0;
    host_oe = 1'b0;
    last_val = 4'h0;
    oe_seen = 0;
  end

  // ----------------------------------------
  // lane resolution
  // ----------------------------------------
  // a lane nobody drives toggles every edge so a stale value never passes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (host_oe) begin
        dq_in[i] = host_val[i];
      end else if (dq_drive.dq_oe[i]) begin
        dq_in[i] = dq_drive.dq_out[i];
      end else begin
        dq_in[i] = ~last_val[i];
      end
    end
  end

  always @(posedge link_clock) begin
    last_val <= dq_in;
  end

  // ----------------------------------------
  // framing
  // ----------------------------------------
  task automatic tick();
    #15 link_clock = 1'b1;
    #15 link_clock = 1'b0;
  endtask

  task automatic idle_edges(input int n);
    repeat (n) tick();
  endtask

  task automatic send_frame(input logic [7:0] b[$], input int reply, input int gap);
    cs_n = 1'b0;
    host_oe = 1'b1;
    host_val = 4'h0;
    // the device delays lanes as far as select, so the first edge already carries data
    foreach (b[i]) begin
      #(gap);
      host_val = b[i][7:4];
      tick();
      host_val = b[i][3:0];
      tick();
    end
    host_oe = 1'b0;
    oe_seen = 0;
    repeat (reply) begin
      tick();
      if (dq_drive.dq_oe === 4'hF) oe_seen++;
    end
    cs_n = 1'b1;
    // enough edges for the deselect to pass the synchroniser and clear the frame
    idle_edges(5);
  endtask
endmodule

/* dv/tb_top.sv */
// self-checking bench for the four-lane command decoder
`timescale 1ns/100ps
module tb_top;
  import qcmd_pkg::*;
  typedef struct packed {
    cmd_kind_t   kind;
    logic [31:0] addr;
    logic [7:0]  data;
  } note_t;

  logic            clock, sys_rst, link_clock, cs_n, addr_4byte_mode, wel_set, wel_clear;
  logic [3:0]      dq_in;
  lane_drive_t     dq_drive;
  logic            core_busy, core_busy_prog_erase, suspend_req, resume_req, suspended;
  logic            erase_eval_req, otp_prog_req, otp_prog_done;
  logic [31:0]     otp_prog_addr, lookup_addr, a, ea;
  logic [7:0]      otp_prog_data, wear_count_byte, otp_read_byte, prot_byte, d, op;
  note_t           notes[$];
  int              error_cnt, cmp_count, na;
  logic [7:0]      sus_ops[3] = '{OP_SUSPEND, OP_SUSPEND_ALT_A, OP_SUSPEND_ALT_B};
  logic [7:0]      res_ops[3] = '{OP_RESUME, OP_RESUME_ALT_A, OP_RESUME_ALT_B};
  logic [7:0]      rd_ops[4] = '{OP_WEAR_COUNT, OP_OTP_READ, OP_PROT_READ_CUR, OP_PROT_READ_4B};

  quad_io_cmd_decode u_quad_io_cmd_decode (.clock(clock), .sys_rst(sys_rst),
    .link_clock(link_clock), .cs_n(cs_n), .dq_in(dq_in), .dq_drive(dq_drive),
    .addr_4byte_mode(addr_4byte_mode), .wel_set(wel_set), .wel_clear(wel_clear),
    .core_busy(core_busy), .core_busy_prog_erase(core_busy_prog_erase),
    .suspend_req(suspend_req), .resume_req(resume_req), .suspended(suspended),
    .erase_eval_req(erase_eval_req), .otp_prog_req(otp_prog_req),
    .otp_prog_addr(otp_prog_addr), .otp_prog_data(otp_prog_data),
    .otp_prog_done(otp_prog_done), .lookup_addr(lookup_addr),
    .wear_count_byte(wear_count_byte), .otp_read_byte(otp_read_byte),
    .prot_byte(prot_byte));

  host_qspi_model u_host_qspi_model (.link_clock(link_clock), .cs_n(cs_n),
    .dq_in(dq_in), .dq_drive(dq_drive));

  always #20 clock = ~clock;

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check_note(input note_t seen);
    note_t exp;
    cmp_count++;
    if (notes.size() == 0) begin
      error_cnt++;
      $display("FAIL core_event expected none seen %h", seen);
    end else begin
      exp = notes.pop_front();
      if (seen !== exp) begin
        error_cnt++;
        $display("FAIL core_event expected %h seen %h", exp, seen);
      end
    end
  endtask

  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // every core pulse must match the oldest note
  always @(posedge clock) begin
    if (sys_rst === 1'b0) begin
      if (suspend_req !== 1'b0) check_note('{CMD_SUSPEND, 32'h0, 8'h0});
      if (resume_req !== 1'b0) check_note('{CMD_RESUME, 32'h0, 8'h0});
      if (erase_eval_req !== 1'b0) check_note('{CMD_ERASE_EVAL, lookup_addr, 8'h0});
      if (otp_prog_req !== 1'b0) check_note('{CMD_OTP_PROG, otp_prog_addr, otp_prog_data});
      if (wel_clear !== 1'b0) check_note('{CMD_NONE, 32'h0, 8'h0});
    end
  end

  // the core finishes each program step one cycle after it is asked
  always @(posedge clock) otp_prog_done <= (otp_prog_req === 1'b1);

  task automatic frame(input logic [7:0] o, input int n, input logic [31:0] ad,
                       input int nd, input logic [7:0] dv, input int reply);
    logic [7:0] q[$];
    q = {o};
    for (int i = n - 1; i >= 0; i--) q.push_back(ad[8*i +: 8]);
    for (int i = 0; i < nd; i++) q.push_back(dv + 8'(i));
    @(posedge clock);
    u_host_qspi_model.send_frame(q, reply, $urandom_range(40, 0));
    repeat (30) @(posedge clock);
  endtask

  initial begin
    #1000000;
    error_cnt++;
    $display("FAIL watchdog expected finish seen hang");
    stop_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    {addr_4byte_mode, wel_set, core_busy, core_busy_prog_erase, otp_prog_done} = 5'h00;
    {wear_count_byte, otp_read_byte, prot_byte} = 24'h0;
    error_cnt = 0;
    cmp_count = 0;
    void'($urandom(50));
    fork
      repeat (4) @(posedge clock);
      u_host_qspi_model.idle_edges(5);
    join
    @(posedge clock);
    sys_rst <= 1'b0;
    core_busy <= 1'b1;
    core_busy_prog_erase <= 1'b1;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 3; i++) begin
      notes.push_back('{CMD_SUSPEND, 32'h0, 8'h0});
      frame(sus_ops[i], 0, 0, 0, 0, 0);
      check_val("suspended", 32'h1, {31'h0, suspended});
      frame(sus_ops[i], 0, 0, 0, 0, 0);
      notes.push_back('{CMD_RESUME, 32'h0, 8'h0});
      frame(res_ops[i], 0, 0, 0, 0, 0);
      check_val("suspended", 32'h0, {31'h0, suspended});
      frame(res_ops[i], 0, 0, 0, 0, 0);
    end
    core_busy_prog_erase <= 1'b0;
    frame(OP_SUSPEND_ALT_B, 0, 0, 0, 0, 0);
    check_val("suspended", 32'h0, {31'h0, suspended});
    core_busy <= 1'b0;
    frame(OP_SUSPEND, 0, 0, 0, 0, 0);
    check_val("suspended", 32'h0, {31'h0, suspended});
    $display("test suspend_resume done");

    for (int m = 0; m < 2; m++) begin
      addr_4byte_mode <= m[0];
      a = $urandom;
      notes.push_back('{CMD_ERASE_EVAL, (m == 1) ? a : {8'h00, a[23:0]}, 8'h0});
      frame(OP_ERASE_EVAL, 3 + m, a, 0, 0, 0);
      for (int k = 0; k < 4; k++) begin
        a = $urandom;
        op = rd_ops[k];
        {wear_count_byte, otp_read_byte, prot_byte} <= 24'($urandom);
        na = (m == 1 || op == OP_PROT_READ_4B) ? 4 : 3;
        ea = (na == 4) ? a : {8'h00, a[23:0]};
        frame(op, na, a, 0, 0, 8);
        check_val("lookup_addr", ea, lookup_addr);
        check_val("reply_lanes", 32'h1, {31'h0, u_host_qspi_model.oe_seen > 0});
      end
    end
    $display("test erase_eval_and_reads done");

    addr_4byte_mode <= 1'b0;
    a = {8'h00, 24'($urandom)};
    d = 8'($urandom);
    frame(OP_OTP_PROGRAM, 3, a, 2, d, 0);
    wel_set <= 1'b1;
    notes.push_back('{CMD_OTP_PROG, a, d});
    notes.push_back('{CMD_OTP_PROG, a + 32'h1, d + 8'h1});
    notes.push_back('{CMD_NONE, 32'h0, 8'h0});
    frame(OP_OTP_PROGRAM, 3, a, 2, d, 0);
    repeat (30) @(posedge clock);
    wel_set <= 1'b0;
    frame(8'h2F, 0, 0, 0, 0, 0);
    check_val("pending_events", 32'h0, 32'(notes.size()));
    $display("test otp_program done");
    stop_test();
  end
endmodule
